//--- exec_map.vh
// Opcode patterns, masks and reset values for the move, multiply and no-op datapath
`ifndef EXEC_MAP_VH
`define EXEC_MAP_VH

`define ADDR_OP_MASK 16'hfe00
`define LIT_OP_MASK 16'hff00
`define LIT_FIELD_MSB 7
`define OP_LOAD_MEM 16'h2000
`define OP_LOAD_LIT 16'h7c00
`define OP_SMUL_MEM 16'h5400
`define OP_UMUL_MEM 16'h5000
`define OP_SMUL_LIT 16'h7300
`define OP_UMUL_LIT 16'h7200
`define OP_NOP 16'h0000

`define ACC_RESET 8'h00
`define PROD_HIGH_RESET 8'h00
`define ZERO_RESET 1'b0
`define PULSE_RESET 1'b0
`define MEM_WRITE_RESET 1'b0
`define EXEC_CYCLES 1

`endif

//--- mul8x8.v
// Combinational 8x8 multiplier, signed or unsigned
`timescale 1ns/1ns
module mul8x8 (
  input wire signed_in,
  input wire [7:0] a_in,
  input wire [7:0] b_in,
  output wire [15:0] product_out
);
  wire [15:0] a_ext;
  wire [15:0] b_ext;

  // Sign or zero extension to 16 bits; the low 16 bits of the product are then
  // exact for both interpretations
  assign a_ext = {{8{signed_in & a_in[7]}}, a_in};
  assign b_ext = {{8{signed_in & b_in[7]}}, b_in};
  assign product_out = a_ext * b_ext;
endmodule // mul8x8

//--- move_multiply_nop_exec.v
// Single-cycle execution of accumulator moves, 8x8 multiplies and no-op
`timescale 1ns/1ns
`include "exec_map.vh"
module move_multiply_nop_exec (
  input wire mclk_in,
  input wire rst_n_in,
  input wire issue_valid_in,
  input wire [15:0] instr_in,
  input wire [7:0] file_register_operand_in,
  output wire [7:0] acc_out,
  output wire [7:0] product_high_byte_out,
  output wire zero_flag_out,
  output wire done_out,
  output wire not_handled_out,
  output wire mem_write_en_out
);
  // ==========================================================================
  // Selector codes
  // ==========================================================================
  localparam [2:0] SEL_NONE = 3'b000;
  localparam [2:0] SEL_LOAD_MEM = 3'b001;
  localparam [2:0] SEL_LOAD_LIT = 3'b010;
  localparam [2:0] SEL_MUL = 3'b011;
  localparam [2:0] SEL_NOP = 3'b100;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  reg [7:0] acc_q;
  reg [7:0] acc_d;
  reg [7:0] product_high_byte_q;
  reg [7:0] product_high_byte_d;
  reg zero_q;
  reg zero_d;
  reg done_q;
  reg done_d;
  reg not_handled_q;
  reg not_handled_d;
  reg mem_write_en_q;
  wire mem_write_en_d;

  reg [2:0] sel;
  reg mul_signed;
  reg mul_from_mem;
  wire [15:0] addr_form;
  wire [15:0] lit_form;
  wire hit_load_mem;
  wire hit_load_lit;
  wire hit_smul_mem;
  wire hit_umul_mem;
  wire hit_smul_lit;
  wire hit_umul_lit;
  wire hit_nop;
  wire [7:0] literal_byte;
  wire [7:0] mul_operand;
  wire [15:0] product;
  wire operand_is_zero;

  // ==========================================================================
  // Opcode match
  // ==========================================================================
  assign addr_form = instr_in & `ADDR_OP_MASK;
  assign lit_form = instr_in & `LIT_OP_MASK;
  assign literal_byte = instr_in[`LIT_FIELD_MSB:0];

  assign hit_load_mem = (addr_form == `OP_LOAD_MEM);
  assign hit_load_lit = (lit_form == `OP_LOAD_LIT);
  // Assumed pattern, mirrors the unsigned memory form
  assign hit_smul_mem = (addr_form == `OP_SMUL_MEM);
  assign hit_umul_mem = (addr_form == `OP_UMUL_MEM);
  assign hit_smul_lit = (lit_form == `OP_SMUL_LIT);
  assign hit_umul_lit = (lit_form == `OP_UMUL_LIT);
  assign hit_nop = (instr_in == `OP_NOP);

  // ==========================================================================
  // Decode
  // ==========================================================================
  // Priority only matters if the patterns ever overlap; today they do not
  always @* begin
    sel = SEL_NONE;
    mul_signed = 1'b0;
    mul_from_mem = 1'b0;
    if (hit_load_mem) begin
      sel = SEL_LOAD_MEM;
    end else if (hit_load_lit) begin
      sel = SEL_LOAD_LIT;
    end else if (hit_smul_mem) begin
      sel = SEL_MUL;
      mul_signed = 1'b1;
      mul_from_mem = 1'b1;
    end else if (hit_umul_mem) begin
      sel = SEL_MUL;
      mul_from_mem = 1'b1;
    end else if (hit_smul_lit) begin
      sel = SEL_MUL;
      mul_signed = 1'b1;
    end else if (hit_umul_lit) begin
      sel = SEL_MUL;
    end else if (hit_nop) begin
      sel = SEL_NOP;
    end
  end

  // ==========================================================================
  // Multiplier
  // ==========================================================================
  assign mul_operand = mul_from_mem ? file_register_operand_in : literal_byte;

  mul8x8 mul8x8_inst (
    .signed_in(mul_signed),
    .a_in(acc_q),
    .b_in(mul_operand),
    .product_out(product)
  );

  // ==========================================================================
  // Zero detect
  // ==========================================================================
  assign operand_is_zero = (file_register_operand_in == 8'h00);

  // ==========================================================================
  // Next state
  // ==========================================================================
  always @* begin
    acc_d = acc_q;
    product_high_byte_d = product_high_byte_q;
    zero_d = zero_q;
    if (issue_valid_in) begin
      case (sel)
        SEL_LOAD_MEM: begin
          acc_d = file_register_operand_in;
          zero_d = operand_is_zero;
        end
        SEL_LOAD_LIT: begin
          acc_d = literal_byte;
        end
        SEL_MUL: begin
          // Zero flag deliberately untouched
          acc_d = product[7:0];
          product_high_byte_d = product[15:8];
        end
        default: begin
          // No-op and foreign opcodes hold all state
          acc_d = acc_q;
        end
      endcase
    end
  end

  // ==========================================================================
  // Status pulses
  // ==========================================================================
  // Every handled opcode retires one cycle after issue
  always @* begin
    done_d = 1'b0;
    not_handled_d = 1'b0;
    if (issue_valid_in) begin
      if (sel == SEL_NONE) begin
        not_handled_d = 1'b1;
      end else begin
        done_d = 1'b1;
      end
    end
  end

  // This group never writes data memory
  assign mem_write_en_d = 1'b0;

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Reset values are a local choice; all state starts cleared
  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      acc_q <= `ACC_RESET;
    end else begin
      acc_q <= acc_d;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      product_high_byte_q <= `PROD_HIGH_RESET;
    end else begin
      product_high_byte_q <= product_high_byte_d;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      zero_q <= `ZERO_RESET;
    end else begin
      zero_q <= zero_d;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      done_q <= `PULSE_RESET;
    end else begin
      done_q <= done_d;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      not_handled_q <= `PULSE_RESET;
    end else begin
      not_handled_q <= not_handled_d;
    end
  end

  always @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_write_en_q <= `MEM_WRITE_RESET;
    end else begin
      mem_write_en_q <= mem_write_en_d;
    end
  end

  // ==========================================================================
  // Outputs
  // ==========================================================================
  assign acc_out = acc_q;
  assign product_high_byte_out = product_high_byte_q;
  assign zero_flag_out = zero_q;
  assign done_out = done_q;
  assign not_handled_out = not_handled_q;
  assign mem_write_en_out = mem_write_en_q;
endmodule // move_multiply_nop_exec

//--- move_multiply_nop_exec_props.sv
// Concurrent checks for the move, multiply and no-op datapath
`timescale 1ns/1ns
`include "exec_map.vh"
module move_multiply_nop_exec_props (
  input wire mclk_in,
  input wire rst_n_in,
  input wire issue_valid_in,
  input wire [15:0] instr_in,
  input wire [7:0] file_register_operand_in,
  input wire [7:0] acc_out,
  input wire [7:0] product_high_byte_out,
  input wire zero_flag_out,
  input wire done_out,
  input wire not_handled_out,
  input wire mem_write_en_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire [15:0] am = instr_in & `ADDR_OP_MASK;
  wire [15:0] lm = instr_in & `LIT_OP_MASK;
  wire [7:0] d = file_register_operand_in;
  wire [7:0] k = instr_in[7:0];
  wire [15:0] res = {product_high_byte_out, acc_out};
  wire [15:0] sa = {{8{acc_out[7]}}, acc_out};
  wire [15:0] p_sf = sa * {{8{d[7]}}, d};
  wire [15:0] p_sl = sa * {{8{k[7]}}, k};
  wire [15:0] p_uf = acc_out * d;
  wire [15:0] p_ul = acc_out * k;
  sequence s_mul;
    issue_valid_in && (am == `OP_SMUL_MEM || am == `OP_UMUL_MEM ||
      lm == `OP_SMUL_LIT || lm == `OP_UMUL_LIT);
  endsequence
  sequence s_idle;
    !issue_valid_in;
  endsequence
  a_load_mem: assert property (issue_valid_in && am == `OP_LOAD_MEM |=>
    acc_out == $past(d) && zero_flag_out == ($past(d) == 8'h00)) else $error("load mem");
  a_load_lit: assert property (issue_valid_in && lm == `OP_LOAD_LIT |=>
    acc_out == $past(k) && $stable(zero_flag_out)) else $error("load lit");
  a_smul_mem: assert property (issue_valid_in && am == `OP_SMUL_MEM |=>
    res == $past(p_sf)) else $error("smul mem");
  a_smul_lit: assert property (issue_valid_in && lm == `OP_SMUL_LIT |=>
    res == $past(p_sl)) else $error("smul lit");
  a_umul_mem: assert property (issue_valid_in && am == `OP_UMUL_MEM |=>
    res == $past(p_uf)) else $error("umul mem");
  a_umul_lit: assert property (issue_valid_in && lm == `OP_UMUL_LIT |=>
    res == $past(p_ul)) else $error("umul lit");
  a_idle_quiet: assert property (s_idle |=>
    !done_out && !not_handled_out && $stable(res) && $stable(zero_flag_out))
    else $error("idle");
  a_mul_flag_kept: assert property (s_mul |=>
    done_out && $stable(zero_flag_out)) else $error("mul flag or done");
  a_nop_idle: assert property (issue_valid_in && instr_in == `OP_NOP |=>
    done_out && $stable(res) && $stable(zero_flag_out)) else $error("nop");
  a_no_mem_write: assert property (!mem_write_en_out) else $error("mem write");
endmodule // move_multiply_nop_exec_props
bind move_multiply_nop_exec move_multiply_nop_exec_props props_inst (.mclk_in, .rst_n_in,
  .issue_valid_in, .instr_in, .file_register_operand_in, .acc_out, .product_high_byte_out,
  .zero_flag_out, .done_out, .not_handled_out, .mem_write_en_out);

//--- move_multiply_nop_exec_test.sv
// Random self-checking bench for the move, multiply and no-op datapath
`timescale 1ns/1ns
`include "exec_map.vh"
module move_multiply_nop_exec_test;
  reg mclk_in = 0, rst_n_in = 0, v = 0;
  reg [15:0] ins = 16'h0000, r;
  reg [7:0] opd = 8'h00;
  wire [7:0] acc, ph;
  wire z, dn, nh, mw;
  reg [18:0] e = 19'h00000;
  reg [15:0] ops [0:7] = '{`OP_LOAD_MEM, `OP_LOAD_LIT, `OP_SMUL_MEM, `OP_UMUL_MEM,
    `OP_SMUL_LIT, `OP_UMUL_LIT, `OP_NOP, 16'h2400};
  reg [23:0] cc [0:11] = '{24'h7c0500, 24'h730600, 24'h7cf900, 24'h549906, 24'h7cf900,
    24'h73fa00, 24'h209900, 24'h000000, 24'h7cff00, 24'h72ff00, 24'h5155ff, 24'h24aa00};
  integer error_cnt = 0, total_checks = 0, n;
  move_multiply_nop_exec move_multiply_nop_exec_inst (.mclk_in(mclk_in), .rst_n_in(rst_n_in),
    .issue_valid_in(v), .instr_in(ins), .file_register_operand_in(opd), .acc_out(acc),
    .product_high_byte_out(ph), .zero_flag_out(z), .done_out(dn), .not_handled_out(nh),
    .mem_write_en_out(mw));
  // ==========
  // Expectation
  function [15:0] mul(input s, input [7:0] a, input [7:0] b);
    mul = s ? {{8{a[7]}}, a} * {{8{b[7]}}, b} : {8'h00, a} * b;
  endfunction
  // Packed as {refused, done, zero, high, acc}
  function [18:0] model(input [15:0] i, input [7:0] d, input [18:0] p);
    reg [15:0] am, lm;
    begin
      am = i & `ADDR_OP_MASK;
      lm = i & `LIT_OP_MASK;
      model = {2'b01, p[16:0]};
      if (am == `OP_LOAD_MEM) model[16:0] = {d == 8'h00, p[15:8], d};
      else if (lm == `OP_LOAD_LIT) model[7:0] = i[7:0];
      else if (am == `OP_SMUL_MEM) model[15:0] = mul(1'b1, p[7:0], d);
      else if (am == `OP_UMUL_MEM) model[15:0] = mul(1'b0, p[7:0], d);
      else if (lm == `OP_SMUL_LIT) model[15:0] = mul(1'b1, p[7:0], i[7:0]);
      else if (lm == `OP_UMUL_LIT) model[15:0] = mul(1'b0, p[7:0], i[7:0]);
      else if (i != `OP_NOP) model = {2'b10, p[16:0]};
    end
  endfunction
  task chk(input string nm, input [15:0] x, input [15:0] g);
    begin
      total_checks = total_checks + 1;
      if (g !== x) begin
        error_cnt = error_cnt + 1;
        $display("FAIL %0s expected %h seen %h", nm, x, g);
      end
    end
  endtask
  // Checks the previous issue while driving the next, so issues run back to back
  task run(input vl, input [15:0] i, input [7:0] d);
    begin
      @(posedge mclk_in);
      v <= vl;
      ins <= i;
      opd <= d;
      #1;
      chk("result", e[15:0], {ph, acc});
      chk("flags", {12'h000, e[18:16], 1'b0}, {12'h000, nh, dn, z, mw});
      e = vl ? model(i, d, e) : {2'b00, e[16:0]};
    end
  endtask
  task final_report;
    begin
      if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
    end
  endtask
  initial begin
    forever #4 mclk_in = ~mclk_in;
  end
  initial begin
    #20000;
    error_cnt = error_cnt + 1;
    final_report;
  end
  initial begin
    n = $urandom(265);
    repeat (12) @(posedge mclk_in);
    rst_n_in <= 1;
    foreach (cc[j]) run(1'b1, cc[j][23:8], cc[j][7:0]);
    repeat (400) begin
      r = ops[$urandom % 8];
      n = $urandom;
      r = r | (n[15:0] & (r == 16'h0000 ? 16'h0000 : r[15:12] == 4'h7 ? 16'h00ff : 16'h01ff));
      n = $urandom;
      run(n[4:2] != 3'h0, r, n[1:0] == 2'b00 ? 8'h00 : n[15:8]);
    end
    // Mid-run reset; the next run checks every output back at its cleared value
    @(posedge mclk_in);
    rst_n_in <= 1'b0;
    v <= 1'b0;
    e = 19'h00000;
    repeat (2) @(posedge mclk_in);
    rst_n_in <= 1'b1;
    run(1'b1, 16'h7c80, 8'h00);
    run(1'b1, 16'h7380, 8'h00);
    run(1'b0, 16'h0000, 8'h00);
    run(1'b0, 16'h0000, 8'h00);
    final_report;
  end
endmodule // move_multiply_nop_exec_test
